// ==== logic/sibs_pkg.sv ====
// constants and types shared by the indexed block smbus slave
package sibs_pkg;
   localparam logic [7:0] SIBS_ADDR_WR   = 8'hdc;
   localparam logic [7:0] SIBS_ADDR_RD   = 8'hdd;
   localparam int         SIBS_NUM_REGS  = 7;
   localparam logic [7:0] SIBS_IDX_ID    = 8'h04;
   localparam logic [7:0] SIBS_IDX_COUNT = 8'h06;
   localparam logic [3:0] SIBS_LAST_BIT  = 4'h7;
   localparam logic [3:0] SIBS_ACK_BIT   = 4'h8;
   localparam logic [7:0] SIBS_RST_FREQ  = 8'h07;
   localparam logic [7:0] SIBS_RST_OE    = 8'h66;
   localparam logic [7:0] SIBS_RST_STOP  = 8'h00;
   localparam logic [7:0] SIBS_RST_SPARE = 8'h00;
   // identification bytes: values are arbitrary
   localparam logic [7:0] SIBS_RST_VREV  = 8'h5a;
   localparam logic [7:0] SIBS_RST_DEVID = 8'h3c;
   localparam logic [7:0] SIBS_RST_COUNT = 8'h07;
   localparam logic [7:0] SIBS_RST_VALS [SIBS_NUM_REGS] = '{SIBS_RST_FREQ, SIBS_RST_OE,
      SIBS_RST_STOP, SIBS_RST_SPARE, SIBS_RST_VREV, SIBS_RST_DEVID, SIBS_RST_COUNT};

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_RDATA}
      sibs_state_t;
endpackage

// ==== logic/sibs_slave.sv ====
// smbus indexed block write / block read slave with a two-entry update buffer
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Operation
// - data bytes stored at successive indexes, except at the id index 4 and past the table
// - device acknowledges written data bytes up to the count while the update buffer has room
// - device acknowledges read address dd
// - first read byte is the count
// - then contents from index onward
// - read count comes from count register
module sibs_slave
   import sibs_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic       upd_ready_in,
   output logic            upd_valid_out,
   output logic [7:0]      upd_index_out,
   output logic [7:0]      upd_data_out,
   output logic [7:0]      ctrl_freq_out,
   output logic [7:0]      ctrl_oe_out,
   output logic [7:0]      ctrl_stop_out
);

   logic              scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic              sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic              rise_ev, fall_ev, start_ev, stop_ev;
   sibs_state_t       st_reg, st_next;
   logic [3:0]        bitcnt_reg, bitcnt_next;
   logic              seen_reg, seen_next;
   logic [7:0]        shreg_reg, shreg_next;
   logic              oe_reg, oe_next;
   logic [7:0]        idx_reg, idx_next;
   logic [7:0]        remain_reg, remain_next;
   logic              mack_reg, mack_next;
   logic              push;
   logic              pop;
   logic              head_v_reg, head_v_next, tail_v_reg, tail_v_next;
   logic [7:0]        head_idx_reg, head_idx_next, tail_idx_reg, tail_idx_next;
   logic [7:0]        head_dat_reg, head_dat_next, tail_dat_reg, tail_dat_next;
   logic [7:0]        regs_reg [SIBS_NUM_REGS];
   logic [7:0]        regs_next [SIBS_NUM_REGS];

   function automatic logic is_ours(input logic [7:0] addr);
      is_ours = (addr == SIBS_ADDR_WR) || (addr == SIBS_ADDR_RD);
   endfunction

   // indexes past the table read as zero
   function automatic logic [7:0] read_byte(input logic [7:0] idx,
                                            input logic [7:0] regs [SIBS_NUM_REGS]);
      read_byte = 8'h00;
      if (idx < 8'(SIBS_NUM_REGS))
         read_byte = regs[idx[2:0]];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus event detection
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg  <= 1'b1;
      end
      else
      begin
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg  <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg  <= sda_s2_reg;
      end
   end

   assign rise_ev  = scl_s2_reg & ~scl_d_reg;
   assign fall_ev  = ~scl_s2_reg & scl_d_reg;
   assign start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign stop_ev  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // byte engine: samples on scl rise, changes sda after scl fall
   always_comb
   begin
      st_next     = st_reg;
      bitcnt_next = bitcnt_reg;
      seen_next   = seen_reg;
      shreg_next  = shreg_reg;
      oe_next     = oe_reg;
      idx_next    = idx_reg;
      remain_next = remain_reg;
      mack_next   = mack_reg;
      push        = 1'b0;
      if (stop_ev)
      begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end
      else if (start_ev)
      begin
         st_next     = ST_ADDR;
         bitcnt_next = 4'h0;
         seen_next   = 1'b0;
         oe_next     = 1'b0;
      end
      else if (st_reg != ST_IDLE && rise_ev)
      begin
         // the fall that follows a start carries no bit; seen gates it out
         seen_next = 1'b1;
         if (bitcnt_reg == SIBS_ACK_BIT)
            mack_next = ~sda_s2_reg;
         else if (st_reg != ST_RDATA)
            shreg_next = {shreg_reg[6:0], sda_s2_reg};
      end
      else if (st_reg != ST_IDLE && fall_ev && seen_reg)
      begin
         seen_next = 1'b0;
         if (bitcnt_reg == SIBS_LAST_BIT)
         begin
            bitcnt_next = SIBS_ACK_BIT;
            oe_next     = 1'b0;
            case (st_reg)
               ST_ADDR:
               begin
                  oe_next = is_ours(shreg_reg);
                  if (!is_ours(shreg_reg))
                     st_next = ST_IDLE;
               end
               ST_INDEX:
               begin
                  oe_next  = 1'b1;
                  idx_next = shreg_reg;
               end
               ST_COUNT:
               begin
                  oe_next     = 1'b1;
                  remain_next = shreg_reg;
               end
               ST_WDATA:
               begin
                  // a full buffer or a surplus byte is refused with a nack
                  if (remain_reg != 8'h00 && !tail_v_reg)
                  begin
                     oe_next     = 1'b1;
                     push        = 1'b1;
                     idx_next    = 8'(idx_reg + 8'h01);
                     remain_next = 8'(remain_reg - 8'h01);
                  end
               end
               default: oe_next = 1'b0;
            endcase
         end
         else if (bitcnt_reg == SIBS_ACK_BIT)
         begin
            bitcnt_next = 4'h0;
            oe_next     = 1'b0;
            case (st_reg)
               ST_ADDR:
               begin
                  if (shreg_reg == SIBS_ADDR_RD)
                  begin
                     st_next    = ST_RDATA;
                     shreg_next = read_byte(SIBS_IDX_COUNT, regs_reg);
                     oe_next    = ~shreg_next[7];
                  end
                  else
                     st_next = ST_INDEX;
               end
               ST_INDEX: st_next = ST_COUNT;
               ST_COUNT: st_next = ST_WDATA;
               ST_RDATA:
               begin
                  if (mack_reg)
                  begin
                     shreg_next = read_byte(idx_reg, regs_reg);
                     idx_next   = 8'(idx_reg + 8'h01);
                     oe_next    = ~shreg_next[7];
                  end
                  else
                     st_next = ST_IDLE;
               end
               default: st_next = st_reg;
            endcase
         end
         else
         begin
            bitcnt_next = 4'(bitcnt_reg + 4'h1);
            if (st_reg == ST_RDATA)
            begin
               shreg_next = {shreg_reg[6:0], 1'b0};
               oe_next    = ~shreg_next[7];
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_reg     <= ST_IDLE;
         bitcnt_reg <= 4'h0;
         seen_reg   <= 1'b0;
         shreg_reg  <= 8'h00;
         oe_reg     <= 1'b0;
         idx_reg    <= 8'h00;
         remain_reg <= 8'h00;
         mack_reg   <= 1'b0;
      end
      else
      begin
         st_reg     <= st_next;
         bitcnt_reg <= bitcnt_next;
         seen_reg   <= seen_next;
         shreg_reg  <= shreg_next;
         oe_reg     <= oe_next;
         idx_reg    <= idx_next;
         remain_reg <= remain_next;
         mack_reg   <= mack_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-entry update buffer; head entry feeds the ports directly
   assign pop = head_v_reg & upd_ready_in;

   always_comb
   begin
      head_v_next   = head_v_reg;
      head_idx_next = head_idx_reg;
      head_dat_next = head_dat_reg;
      tail_v_next   = tail_v_reg;
      tail_idx_next = tail_idx_reg;
      tail_dat_next = tail_dat_reg;
      if (pop)
      begin
         head_v_next   = tail_v_reg;
         head_idx_next = tail_idx_reg;
         head_dat_next = tail_dat_reg;
         tail_v_next   = 1'b0;
      end
      if (push && !head_v_next)
      begin
         head_v_next   = 1'b1;
         head_idx_next = idx_reg;
         head_dat_next = shreg_reg;
      end
      else if (push)
      begin
         tail_v_next   = 1'b1;
         tail_idx_next = idx_reg;
         tail_dat_next = shreg_reg;
      end
   end

   // the register table is written only as entries leave the buffer
   always_comb
   begin
      for (int i = 0; i < SIBS_NUM_REGS; i++)
         regs_next[i] = regs_reg[i];
      if (pop && head_idx_reg < 8'(SIBS_NUM_REGS) && head_idx_reg != SIBS_IDX_ID)
         regs_next[head_idx_reg[2:0]] = head_dat_reg;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         head_v_reg   <= 1'b0;
         head_idx_reg <= 8'h00;
         head_dat_reg <= 8'h00;
         tail_v_reg   <= 1'b0;
         tail_idx_reg <= 8'h00;
         tail_dat_reg <= 8'h00;
         for (int i = 0; i < SIBS_NUM_REGS; i++)
            regs_reg[i] <= SIBS_RST_VALS[i];
      end
      else
      begin
         head_v_reg   <= head_v_next;
         head_idx_reg <= head_idx_next;
         head_dat_reg <= head_dat_next;
         tail_v_reg   <= tail_v_next;
         tail_idx_reg <= tail_idx_next;
         tail_dat_reg <= tail_dat_next;
         for (int i = 0; i < SIBS_NUM_REGS; i++)
            regs_reg[i] <= regs_next[i];
      end
   end

   // open drain: only ever pulls low
   assign sda_out       = 1'b0;
   assign sda_oe_out    = oe_reg;
   assign upd_valid_out = head_v_reg;
   assign upd_index_out = head_idx_reg;
   assign upd_data_out  = head_dat_reg;
   assign ctrl_freq_out = regs_reg[0];
   assign ctrl_oe_out   = regs_reg[1];
   assign ctrl_stop_out = regs_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   logic ack_dec, ack_end;
   assign ack_dec = fall_ev && seen_reg && bitcnt_reg == SIBS_LAST_BIT && st_reg != ST_IDLE;
   assign ack_end = fall_ev && seen_reg && bitcnt_reg == SIBS_ACK_BIT;

   // byte that the read engine should load next, kept apart from the engine's own path
   logic [7:0] rd_exp_reg;
   always_ff @(posedge clk_in)
      rd_exp_reg <= read_byte(idx_reg, regs_reg);

   addr_nack_a: assert property (ack_dec && st_reg == ST_ADDR && !is_ours(shreg_reg)
      |=> (st_reg == ST_IDLE && !oe_reg) [*4]) else $error("foreign address not ignored");
   addr_ack_a: assert property (ack_dec && st_reg == ST_ADDR && is_ours(shreg_reg)
      |=> oe_reg && bitcnt_reg == SIBS_ACK_BIT) else $error("own address not acked");
   ctl_ack_a: assert property (ack_dec && (st_reg == ST_INDEX || st_reg == ST_COUNT)
      |=> oe_reg) else $error("index or count not acked");
   data_ack_a: assert property (ack_dec && st_reg == ST_WDATA && remain_reg != 8'h00
      && !tail_v_reg |=> oe_reg && remain_reg == 8'($past(remain_reg) - 8'h01))
      else $error("data byte not acked");
   full_nack_a: assert property (ack_dec && st_reg == ST_WDATA && tail_v_reg
      |=> !oe_reg) else $error("byte acked with full buffer");
   reg_store_a: assert property (pop && head_idx_reg < 8'h07 && head_idx_reg != SIBS_IDX_ID
      |=> regs_reg[$past(head_idx_reg[2:0])] == $past(head_dat_reg))
      else $error("buffered byte not stored");
   count_first_a: assert property (ack_end && st_reg == ST_ADDR && shreg_reg == SIBS_ADDR_RD
      |=> st_reg == ST_RDATA && shreg_reg == $past(regs_reg[SIBS_IDX_COUNT[2:0]]))
      else $error("count not first");
   read_next_a: assert property (ack_end && st_reg == ST_RDATA && mack_reg
      |=> shreg_reg == rd_exp_reg && idx_reg == 8'($past(idx_reg) + 8'h01))
      else $error("wrong read byte");
   tx_drive_a: assert property (st_reg == ST_RDATA && bitcnt_reg != SIBS_ACK_BIT
      |-> oe_reg == !shreg_reg[7]) else $error("sda does not follow data bit");

   write_cv: cover property (push ##1 push [*1]);
   read_cv: cover property (ack_end && st_reg == ST_RDATA && mack_reg);
   foreign_cv: cover property (ack_dec && st_reg == ST_ADDR && !is_ours(shreg_reg));
   full_cv: cover property (tail_v_reg && !upd_ready_in);
endmodule

// ==== testbench/sibs_host_model.sv ====
// smbus host model that drives the link clock and pulls the data line
`timescale 1ns/1ns
module sibs_host_model (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   localparam time Q = 100;
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // data falls while the clock is high; also serves as a repeated start
   task automatic start_bit();
      #Q sda_low_out = 1'b0;
      #Q scl_out = 1'b1;
      #(2*Q) sda_low_out = 1'b1;
      #(2*Q) scl_out = 1'b0;
   endtask
   // the clock then stands high until the next frame
   task automatic stop_bit();
      #Q sda_low_out = 1'b1;
      #Q scl_out = 1'b1;
      #(2*Q) sda_low_out = 1'b0;
      #(2*Q);
   endtask
   // nine bits, the last is the acknowledge slot; sampled late in the high
   // phase because the slave answers some cycles after the clock falls
   task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         #Q sda_low_out = ~tx[i];
         #Q scl_out = 1'b1;
         #(2*Q-20) rx[i] = sda_in;
         #20 scl_out = 1'b0;
      end
   endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the indexed block smbus slave
`timescale 1ns/1ns
module testbench;
   import sibs_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       upd_ready_in = 1'b1;
   logic       scl_w;
   logic       host_low;
   logic       sda_w;
   logic       sda_out;
   logic       sda_oe_out;
   logic       upd_valid_out;
   logic [7:0] upd_index_out;
   logic [7:0] upd_data_out;
   logic [7:0] ctrl_freq_out;
   logic [7:0] ctrl_oe_out;
   logic [7:0] ctrl_stop_out;
   int         err_count = 0;
   int         cmp_count = 0;

   always #25 clk_in = ~clk_in;
   // open drain wire with pull-up
   assign sda_w = ~(host_low | (sda_oe_out & ~sda_out));

   sibs_slave dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .upd_ready_in(upd_ready_in),
      .upd_valid_out(upd_valid_out), .upd_index_out(upd_index_out),
      .upd_data_out(upd_data_out), .ctrl_freq_out(ctrl_freq_out),
      .ctrl_oe_out(ctrl_oe_out), .ctrl_stop_out(ctrl_stop_out));
   sibs_host_model host (.sda_in(sda_w), .scl_out(scl_w), .sda_low_out(host_low));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] d, input logic ack);
      logic [8:0] rx;
      host.byte_io({d, 1'b1}, rx);
      chk8("ack", {7'h0, ack}, {7'h0, ~rx[0]});
   endtask
   task automatic rd(input logic [7:0] exp, input logic last);
      logic [8:0] rx;
      host.byte_io({8'hff, last}, rx);
      chk8("read byte", exp, rx[8:1]);
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   task automatic wr_open(input logic [7:0] idx, input logic [7:0] cnt);
      host.start_bit();
      wr(SIBS_ADDR_WR, 1'b1);
      wr(idx, 1'b1);
      wr(cnt, 1'b1);
   endtask
   task automatic rd_open(input logic [7:0] idx);
      host.start_bit();
      wr(SIBS_ADDR_WR, 1'b1);
      wr(idx, 1'b1);
      host.start_bit();
      wr(SIBS_ADDR_RD, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_read();
      chk8("ctrl_freq", SIBS_RST_FREQ, ctrl_freq_out);
      chk8("ctrl_oe", SIBS_RST_OE, ctrl_oe_out);
      chk8("ctrl_stop", SIBS_RST_STOP, ctrl_stop_out);
      chk8("upd_valid", 8'h00, {7'h0, upd_valid_out});
      rd_open(8'h00);
      rd(SIBS_RST_COUNT, 1'b0);
      for (int i = 0; i < SIBS_NUM_REGS; i++)
      begin
         rd(SIBS_RST_VALS[i], i == SIBS_NUM_REGS - 1);
      end
      host.stop_bit();
      $display("test reset_read done");
   endtask
   task automatic t_write();
      wr_open(8'h01, 8'h02);
      wr(8'ha5, 1'b1);
      wr(8'h3c, 1'b1);
      wr(8'h77, 1'b0);
      host.stop_bit();
      wait_clk(4);
      chk8("ctrl_oe", 8'ha5, ctrl_oe_out);
      chk8("ctrl_stop", 8'h3c, ctrl_stop_out);
      $display("test write done");
   endtask
   task automatic t_bad_addr();
      host.start_bit();
      wr(8'hde, 1'b0);
      wr(8'h00, 1'b0);
      host.stop_bit();
      $display("test bad_addr done");
   endtask
   // a smaller count must shorten the read and end on index start + count - 1
   task automatic t_count();
      wr_open(SIBS_IDX_COUNT, 8'h01);
      wr(8'h03, 1'b1);
      host.stop_bit();
      wait_clk(4);
      rd_open(8'h05);
      rd(8'h03, 1'b0);
      rd(SIBS_RST_DEVID, 1'b0);
      rd(8'h03, 1'b0);
      rd(8'h00, 1'b1);
      host.stop_bit();
      $display("test count done");
   endtask
   // receiver stalls: two entries fill, the third byte is refused
   task automatic t_buffer();
      wait_clk(1);
      upd_ready_in = 1'b0;
      wr_open(8'h00, 8'h03);
      wr(8'h11, 1'b1);
      wr(8'h22, 1'b1);
      wr(8'h33, 1'b0);
      host.stop_bit();
      chk8("upd_valid", 8'h01, {7'h0, upd_valid_out});
      chk8("upd_index", 8'h00, upd_index_out);
      chk8("upd_data", 8'h11, upd_data_out);
      wait_clk(1);
      upd_ready_in = 1'b1;
      wait_clk(1);
      upd_ready_in = 1'b0;
      chk8("upd_index", 8'h01, upd_index_out);
      chk8("upd_data", 8'h22, upd_data_out);
      wait_clk(1);
      chk8("ctrl_freq", 8'h11, ctrl_freq_out);
      upd_ready_in = 1'b1;
      wait_clk(3);
      chk8("upd_valid", 8'h00, {7'h0, upd_valid_out});
      chk8("ctrl_oe", 8'h22, ctrl_oe_out);
      $display("test buffer done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clk_in);
      #2 rst_in = 1'b0;
      wait_clk(5);
      t_reset_read();
      t_write();
      t_bad_addr();
      t_count();
      t_buffer();
      finish_test();
   end
   // the tests need roughly 140 us of bus traffic
   initial
   begin
      #1000000;
      err_count++;
      $display("wrong value run time: expected end of tests, seen timeout");
      finish_test();
   end
endmodule
